// >>> fieldbus_slave_status_indicators.sv
`default_nettype none
module fieldbus_slave_status_indicators
	import status_pkg::*;
#(
	parameter int BLINK_HALF = BLINK_HALF_CYC,
	parameter int RESTART_WAIT = RESTART_CYC,
	parameter int PULSE_LEN = PULSE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic powerGood,
	input wire logic selfTestDone,
	input wire logic selfTestPass,
	input wire logic initFail,
	input wire logic internalError,
	input wire logic paramValid,
	input wire logic configBad,
	input wire logic configInPhase,
	input wire logic backplaneError,
	input wire logic backplaneFaster,
	input wire logic busActivity,
	input wire logic shortCircuit,
	input wire logic overload,
	input wire logic overTemp,
	input wire logic [ADDR_W-1:0] addrSelector,
	output logic power_indicator,
	output logic fault_indicator,
	output logic ready_indicator,
	output logic exchange_indicator,
	output logic outPower_indicator,
	output logic outFault_indicator,
	output logic [ADDR_W-1:0] stationAddr,
	output logic stationAddrValid,
	output logic snapshotReq,
	output logic inExchange,
	output logic restarting
);
	// ************************************
	// Checks and blink source
	// ************************************
	initial begin
		if (RESTART_WAIT < 1 || PULSE_LEN < 1) $error("Timing counts must be positive");
	end
	blink_if blinkBus();
	blink_gen #(.HALF_CYC(BLINK_HALF)) blinkGen (.clk(clk), .nrst(nrst), .blink(blinkBus));
	logic blinkOn;
	assign blinkOn = blinkBus.phase;

	// ************************************
	// Start-up sequencer
	// ************************************
	// The restart pulse and stop wait share one counter, since they never overlap.
	phase_t phase_reg, phase_next;
	logic [31:0] tmr_reg, tmr_next;
	logic addrTaken_reg, addrTaken_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic sel0_reg, sel0_next;
	logic snap_reg, snap_next;
	always_comb begin
		phase_next = phase_reg;
		tmr_next = tmr_reg;
		addrTaken_next = addrTaken_reg;
		addr_next = addr_reg;
		snap_next = 1'b0;
		sel0_next = (addrSelector == ADDR_ZERO);
		if (!addrTaken_reg) begin // [RL12]
			addrTaken_next = 1'b1;
			addr_next = addrSelector;
		end else if (sel0_next && !sel0_reg) begin
			snap_next = 1'b1; // [RL13]
		end
		case (phase_reg)
			ST_PULSE: begin // [RL1]
				if (tmr_reg >= 32'(PULSE_LEN - 1)) begin
					tmr_next = 32'h00000000;
					phase_next = ST_SELFTEST;
				end else begin
					tmr_next = tmr_reg + 32'h00000001;
				end
			end
			ST_SELFTEST: begin // [RL15]
				if (backplaneError) begin
					phase_next = ST_STOP;
				end else if (selfTestDone && selfTestPass) begin
					phase_next = ST_READY;
				end
			end
			ST_READY: begin
				if (backplaneError) begin
					phase_next = ST_STOP;
				end else if (paramValid && !configBad && !initFail) begin
					phase_next = ST_EXCHANGE; // [RL15]
				end
			end
			ST_EXCHANGE: begin
				if (backplaneError) begin
					phase_next = ST_STOP;
				end else if (!paramValid) begin
					phase_next = ST_READY;
				end
			end
			ST_STOP: begin // [RL16]
				if (tmr_reg >= 32'(RESTART_WAIT - 1)) begin
					tmr_next = 32'h00000000;
					phase_next = ST_PULSE;
				end else begin
					tmr_next = tmr_reg + 32'h00000001;
				end
			end
			default: begin
				phase_next = ST_PULSE;
				tmr_next = 32'h00000000;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_reg <= ST_PULSE;
			tmr_reg <= 32'h00000000;
			addrTaken_reg <= 1'b0;
			addr_reg <= ADDR_ZERO;
			sel0_reg <= 1'b1;
			snap_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			tmr_reg <= tmr_next;
			addrTaken_reg <= addrTaken_next;
			addr_reg <= addr_next;
			sel0_reg <= sel0_next;
			snap_reg <= snap_next;
		end
	end

	// ************************************
	// Indicator decode
	// ************************************
	// Fault priority: restart pulse, internal error, configuration, initialisation.
	logic fault_next, ready_next;
	always_comb begin
		fault_next = 1'b0;
		ready_next = 1'b0;
		if (phase_reg == ST_PULSE) begin
			fault_next = 1'b1; // [RL1]
		end else if (internalError) begin
			fault_next = 1'b1; // [RL2]
		end else if (configBad) begin
			fault_next = blinkOn;
			ready_next = configInPhase ? blinkOn : ~blinkOn; // [RL4] [RL5]
		end else if (initFail) begin
			fault_next = blinkOn; // [RL3]
		end
		if (!configBad) begin
			if (phase_reg == ST_EXCHANGE) begin
				ready_next = backplaneFaster; // [RL6] [RL7]
			end else if (phase_reg == ST_READY && !initFail) begin
				ready_next = blinkOn; // [RL8]
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			power_indicator <= 1'b0;
			fault_indicator <= 1'b0;
			ready_indicator <= 1'b0;
			exchange_indicator <= 1'b0;
			outPower_indicator <= 1'b0;
			outFault_indicator <= 1'b0;
			stationAddr <= ADDR_ZERO;
			stationAddrValid <= 1'b0;
			snapshotReq <= 1'b0;
			inExchange <= 1'b0;
			restarting <= 1'b0;
		end else begin
			power_indicator <= powerGood;
			fault_indicator <= fault_next;
			ready_indicator <= ready_next;
			exchange_indicator <= busActivity; // [RL9]
			outPower_indicator <= powerGood;
			outFault_indicator <= shortCircuit | overload | overTemp; // [RL10]
			stationAddr <= addr_reg;
			stationAddrValid <= addrTaken_reg && addr_reg >= ADDR_MIN && addr_reg <= ADDR_MAX;
			snapshotReq <= snap_reg;
			inExchange <= (phase_reg == ST_EXCHANGE);
			restarting <= (phase_reg == ST_STOP);
		end
	end

	// ************************************
	// Assertions
	// ************************************
	pulseFault_a: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
		(phase_reg == ST_PULSE) |=> fault_indicator) else $error("No restart pulse");
	internalErr_a: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
		internalError |=> fault_indicator) else $error("Internal error dark");
	initBlink_a: assert property (@(posedge clk) disable iff (!nrst) // [RL3]
		(phase_reg != ST_PULSE && !internalError && !configBad && initFail)
		|=> (fault_indicator == $past(blinkOn))) else $error("Init blink wrong");
	cfgAlt_a: assert property (@(posedge clk) disable iff (!nrst) // [RL4]
		(phase_reg != ST_PULSE && !internalError && configBad && !configInPhase)
		|=> (fault_indicator != ready_indicator)) else $error("Not alternating");
	cfgPhase_a: assert property (@(posedge clk) disable iff (!nrst) // [RL5]
		(phase_reg != ST_PULSE && !internalError && configBad && configInPhase)
		|=> (fault_indicator == ready_indicator)) else $error("Not in phase");
	readyExch_a: assert property (@(posedge clk) disable iff (!nrst) // [RL6] [RL7]
		(phase_reg == ST_EXCHANGE && !configBad) |=> (ready_indicator == $past(backplaneFaster)))
		else $error("Ready wrong in exchange");
	readyBlink_a: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
		(phase_reg == ST_READY && !configBad && !initFail) |=> (ready_indicator == $past(blinkOn)))
		else $error("Ready not blinking");
	exchLed_a: assert property (@(posedge clk) disable iff (!nrst) // [RL9]
		busActivity |=> exchange_indicator) else $error("Activity not shown");
	outFault_a: assert property (@(posedge clk) disable iff (!nrst) // [RL10]
		(shortCircuit || overload || overTemp) |=> outFault_indicator)
		else $error("Output fault dark");
	addrHeld_a: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
		$past(addrTaken_reg) |-> $stable(addr_reg)) else $error("Address changed");
	snapOnce_a: assert property (@(posedge clk) disable iff (!nrst) // [RL13]
		snap_reg |=> !snap_reg) else $error("Snapshot repeated");
	stopToPulse_a: assert property (@(posedge clk) disable iff (!nrst) // [RL16]
		(phase_reg == ST_STOP && tmr_reg == 32'(RESTART_WAIT - 1)) |=> (phase_reg == ST_PULSE))
		else $error("No restart after stop");
	exchEnter_a: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
		(phase_reg == ST_READY && !backplaneError && paramValid && !configBad && !initFail)
		|=> (phase_reg == ST_EXCHANGE)) else $error("Exchange not entered");
	coverExch_c: cover property (@(posedge clk) disable iff (!nrst)
		phase_reg == ST_READY ##1 phase_reg == ST_EXCHANGE);
	coverStop_c: cover property (@(posedge clk) disable iff (!nrst)
		phase_reg == ST_STOP ##1 phase_reg == ST_PULSE);
	coverCfg_c: cover property (@(posedge clk) disable iff (!nrst) configBad && fault_indicator);
	coverSnap_c: cover property (@(posedge clk) disable iff (!nrst) snap_reg);
endmodule : fieldbus_slave_status_indicators
`default_nettype wire

// >>> status_pkg.sv
// Functional notes
// RL1 - Restart pulses fault indicator on then off
// RL2 - Internal error holds fault indicator on
// RL3 - Initialisation failure blinks fault indicator
// RL4 - Bad configuration: fault and ready alternate
// RL5 - Bad configuration option: fault, ready in phase
// RL6 - Exchange with fast backplane: ready on
// RL7 - Exchange with slow backplane: ready off
// RL8 - Ready blinks after init until exchange
// RL9 - Exchange indicator shows fieldbus activity
// RL10 - Output fault on short, overload, overtemperature
// RL11 - Operator keeps address 1..99, unique
// RL12 - Address sampled once at power-on
// RL13 - Selector to 00 saves one snapshot
// RL14 - Master declares output module at location 1
// RL15 - Self-test, ready, then exchange on parameters
// RL16 - Backplane error stops, restarts after 2 s
// RL17 - One shared 1 Hz 50 percent blink
`default_nettype none
package status_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int BLINK_HZ = 1;
	localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int RESTART_S = 2;
	localparam int RESTART_CYC = CLK_HZ * RESTART_S;
	localparam int PULSE_MS = 100;
	localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
	localparam int ADDR_W = 7;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_MIN = 7'h01;
	localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h63;

	typedef enum logic [2:0] {
		ST_PULSE = 3'b000,
		ST_SELFTEST = 3'b001,
		ST_READY = 3'b010,
		ST_EXCHANGE = 3'b011,
		ST_STOP = 3'b100
	} phase_t;
endpackage : status_pkg
`default_nettype wire

// >>> blink_if.sv
`default_nettype none
interface blink_if;
	logic phase;
	modport source(output phase);
	modport sink(input phase);
endinterface : blink_if
`default_nettype wire

// >>> blink_gen.sv
`default_nettype none
module blink_gen
	import status_pkg::*;
#(
	parameter int HALF_CYC = BLINK_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	blink_if.source blink
);
	// ************************************
	// Shared blink timebase
	// ************************************
	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least one");
	end
	logic [31:0] cnt_reg, cnt_next;
	logic phase_reg, phase_next;
	always_comb begin
		cnt_next = cnt_reg + 32'h00000001;
		phase_next = phase_reg;
		if (cnt_reg >= 32'(HALF_CYC - 1)) begin // [RL17]
			cnt_next = 32'h00000000;
			phase_next = ~phase_reg;
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= 32'h00000000;
			phase_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			phase_reg <= phase_next;
		end
	end
	assign blink.phase = phase_reg;
	phaseHold_a: assert property (@(posedge clk) disable iff (!nrst) // [RL17]
		(cnt_reg != 32'(HALF_CYC - 1)) |=> $stable(phase_reg))
		else $error("Blink phase changed early");
	phaseFlip_a: assert property (@(posedge clk) disable iff (!nrst) // [RL17]
		(cnt_reg == 32'(HALF_CYC - 1)) |=> (phase_reg != $past(phase_reg)))
		else $error("Blink phase did not toggle");
endmodule : blink_gen
`default_nettype wire

// >>> fieldbus_master_model.sv
`default_nettype none
module fieldbus_master_model (
	input wire logic clk,
	input wire logic start,
	input wire logic badCfg,
	input wire logic inPhase,
	output logic paramValid,
	output logic configBad,
	output logic configInPhase,
	output logic busActivity
);
	timeunit 1ns;
	timeprecision 1ns;
	// **********************************
	// Master side of the fieldbus.
	// **********************************
	// Outputs move just after the rising edge, so the slave always sees settled levels.
	always @(posedge clk) begin
		paramValid <= start & ~badCfg;
		configBad <= start & badCfg;
		configInPhase <= inPhase;
		busActivity <= start & ~busActivity;
	end
endmodule : fieldbus_master_model
`default_nettype wire

// >>> tb_fieldbus_slave_status_indicators.sv
`default_nettype none
module tb_fieldbus_slave_status_indicators;
	import status_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BH = 4;
	localparam int RW = 20;
	localparam int PL = 3;
	logic clk, nrst, powerGood, stDone, stPass, initFail, intErr, bpErr, bpFast;
	logic shortC, overload, overTemp, start, badCfg, inPhase;
	logic paramValid, configBad, configInPhase, busActivity;
	logic pwr, fault, ready, exch, outPwr, outFault, addrValid, snap, inExch, restarting;
	logic [ADDR_W-1:0] addrSel, addr, stationAddr;
	logic [31:0] seed = 32'hB2EC;
	logic [31:0] r;
	int bad_count, check_count, fOn, rOn, same, snaps, exo, cnt;
	// **********************************
	// Design and master model.
	// **********************************
	fieldbus_slave_status_indicators #(.BLINK_HALF(BH), .RESTART_WAIT(RW), .PULSE_LEN(PL))
			fieldbus_slave_status_indicators_inst (
		.clk(clk), .nrst(nrst), .powerGood(powerGood), .selfTestDone(stDone),
		.selfTestPass(stPass), .initFail(initFail), .internalError(intErr),
		.paramValid(paramValid), .configBad(configBad), .configInPhase(configInPhase),
		.backplaneError(bpErr), .backplaneFaster(bpFast), .busActivity(busActivity),
		.shortCircuit(shortC), .overload(overload), .overTemp(overTemp),
		.addrSelector(addrSel), .power_indicator(pwr), .fault_indicator(fault),
		.ready_indicator(ready), .exchange_indicator(exch), .outPower_indicator(outPwr),
		.outFault_indicator(outFault), .stationAddr(stationAddr),
		.stationAddrValid(addrValid), .snapshotReq(snap), .inExchange(inExch),
		.restarting(restarting));
	fieldbus_master_model fieldbus_master_model_inst (.clk(clk), .start(start),
		.badCfg(badCfg), .inPhase(inPhase), .paramValid(paramValid), .configBad(configBad),
		.configInPhase(configInPhase), .busActivity(busActivity));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Counts indicator activity over a span, sampled at the settled falling edge.
	task automatic watch(input int n);
		{fOn, rOn, same, snaps, exo} = '0;
		repeat (n) begin
			@(negedge clk);
			fOn += (fault === 1'b1);
			rOn += (ready === 1'b1);
			same += (fault === ready);
			snaps += (snap === 1'b1);
			exo += (exch === ~busActivity);
		end
	endtask : watch
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#(40 * 3000);
		bad_count++;
		test_done();
	end
	initial begin
		{powerGood, stDone, stPass, initFail, intErr, bpErr, bpFast} = '0;
		{shortC, overload, overTemp, start, badCfg, inPhase} = '0;
		nrst = 1'b0;
		addr = 7'(rnd() % 99 + 1);
		addrSel = addr;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		check(fault, 1);
		addrSel = 7'h7F;
		watch(9);
		check(fault, 0);
		check({addrValid, stationAddr}, {1'b1, addr});
		repeat (16) begin
			r = rnd();
			{powerGood, shortC, overload, overTemp} = r[3:0];
			@(negedge clk);
			check({outPwr, pwr, outFault}, {r[3], r[3], |r[2:0]});
		end
		{stDone, stPass} = 2'b11;
		watch(4 * BH);
		check(8'(fOn), 0);
		check(rOn > 0 && rOn < 4 * BH, 1);
		initFail = 1'b1;
		watch(4 * BH);
		check({fOn > 0 && fOn < 4 * BH, 7'(rOn)}, 8'h80);
		initFail = 1'b0;
		intErr = 1'b1;
		repeat (2) @(negedge clk);
		watch(10);
		check(8'(fOn), 10);
		intErr = 1'b0;
		{start, badCfg} = 2'b11;
		repeat (3) @(negedge clk);
		watch(4 * BH);
		check({fOn > 0 && fOn < 4 * BH, 7'(same)}, 8'h80);
		inPhase = 1'b1;
		repeat (3) @(negedge clk);
		watch(4 * BH);
		check({fOn > 0 && fOn < 4 * BH, 7'(same)}, {1'b1, 7'(4 * BH)});
		check(8'(fOn), 8'(2 * BH));
		badCfg = 1'b0;
		bpFast = 1'b1;
		repeat (3) @(negedge clk);
		watch(8);
		check({inExch, 7'(rOn)}, 8'h88);
		check(8'(exo), 8);
		bpFast = 1'b0;
		repeat (2) @(negedge clk);
		watch(8);
		check(8'(rOn), 0);
		addrSel = 7'h00;
		watch(8);
		check(8'(snaps), 1);
		watch(8);
		check(8'(snaps), 0);
		addrSel = addr;
		repeat (2) @(negedge clk);
		addrSel = 7'h00;
		watch(8);
		check(8'(snaps), 1);
		bpErr = 1'b1;
		repeat (2) @(negedge clk);
		check({inExch, restarting}, 2'b01);
		bpErr = 1'b0;
		cnt = 0;
		while (restarting === 1'b1 && cnt < 100) begin
			@(negedge clk);
			cnt++;
		end
		check(cnt >= RW - 4 && cnt <= RW + 2, 1);
		watch(4);
		check(fOn > 0, 1);
		check(stationAddr, addr);
		// A second reset takes a fresh selector value; held three cycles so it clears the latch.
		nrst = 1'b0;
		addrSel = 7'h64;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		check(fault, 1);
		check({addrValid, stationAddr}, {1'b0, 7'h64});
		test_done();
	end
endmodule : tb_fieldbus_slave_status_indicators
`default_nettype wire
